/* verification/dps_host_properties.sv */
// dps_host_properties.sv: pin and bus checks on the token controller
// assumes it is bound into dps_host and sees its ports only
`timescale 1ns/1ns
`default_nettype none
module dps_host_properties
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire dps_pkg::dps_pins_s pins
);
  import dps_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // strobes only inside token space, memory never enabled
  a_mem_never_on: assert property (pins.chip_enable_n)
    else $error("memory enable low");
  a_write_in_sel: assert property (
    !pins.write_n |-> !pins.token_select_n) else $error("stray write");
  a_read_in_sel: assert property (
    !pins.output_enable_n |-> !pins.token_select_n) else $error("stray read");
  a_one_strobe: assert property (pins.write_n | pins.output_enable_n)
    else $error("two strobes");
  // only bit zero carries a value, and it is driven while writing
  a_bit_zero: assert property (
    !pins.write_n |-> pins.data_oe && pins.data_out[7:1] == 7'h00)
    else $error("write data bad");
  a_index_held: assert property (
    !pins.token_select_n && $past(!pins.token_select_n)
      |-> $stable(pins.token_index)) else $error("index moved");
  // select drops between accesses so a poll recaptures
  a_sel_drops: assert property (
    $rose(pins.token_select_n) |=> pins.token_select_n[*2])
    else $error("select gap short");
  // one wait state, one-cycle answer
  a_ready_wait: assert property (
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer late");
endmodule : dps_host_properties
bind dps_host dps_host_properties dps_host_properties_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pins(pins));
`default_nettype wire

/* verification/dps_host_tb_top.sv */
// dps_host_tb_top.sv: self-checking bench for the token controller
// assumes dps_token_model stands behind the pins
`timescale 1ns/1ns
`default_nettype none
module dps_host_tb_top;
  import dps_pkg::*;
  typedef struct packed {logic b; logic [2:0] i; logic v; logic [7:0] x;}
    dps_row_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, serr;
  logic sel_b_n = 1'b1;
  logic we_b_n = 1'b1;
  logic bit_b = 1'b0;
  logic [2:0] idx_b = 3'h0;
  logic [7:0] data_in;
  dps_pins_s pins;
  int err_total = 0;
  int check_count = 0;
  dps_row_s rows [9] = '{
    '{1'b0, 3'h3, 1'b0, 8'h00}, '{1'b1, 3'h3, 1'b0, 8'h00},
    '{1'b0, 3'h3, 1'b1, 8'hFF}, '{1'b0, 3'h3, 1'b0, 8'hFF},
    '{1'b1, 3'h3, 1'b1, 8'h00}, '{1'b0, 3'h3, 1'b1, 8'hFF},
    '{1'b1, 3'h3, 1'b0, 8'hFF}, '{1'b0, 3'h5, 1'b0, 8'h00},
    '{1'b0, 3'h6, 1'b1, 8'hFF}};
  // 4 ns period
  always #2 pclk = ~pclk;
  dps_host dps_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .data_in(data_in));
  dps_token_model dps_token_model_inst (.pins(pins), .sel_b_n(sel_b_n),
    .we_b_n(we_b_n), .idx_b(idx_b), .bit_b(bit_b), .data_a(data_in));
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    if (err_total == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // one transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (pready !== 1'b1)
    begin
      err_total++;
      print_verdict();
    end
    else
    begin
      rd = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task automatic cmd(input logic [31:0] c);
    int n;
    n = 0;
    apb(1'b1, 12'h000, c);
    do
    begin
      apb(1'b0, 12'h004, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 60);
    if (rd[0] !== 1'b0)
    begin
      err_total++;
      print_verdict();
    end
  endtask : cmd
  // far-side write, select around the strobe
  task automatic b_write(input logic [2:0] i, input logic v);
    @(posedge pclk);
    sel_b_n <= 1'b0;
    idx_b <= i;
    bit_b <= v;
    @(posedge pclk);
    we_b_n <= 1'b0;
    repeat (4) @(posedge pclk);
    we_b_n <= 1'b1;
    @(posedge pclk);
    sel_b_n <= 1'b1;
  endtask : b_write
  initial
  begin
    repeat (20) @(posedge pclk);
    check({pready, prdata}, 33'h0);
    check({pins.token_select_n, pins.chip_enable_n, pins.data_oe}, 3'h6);
    presetn <= 1'b1;
    cmd(32'h0000_0107);
    for (int i = 0; i < 8; i++)
      b_write(3'(i), 1'b1);
    apb(1'b0, 12'h004, 32'h0);
    check(rd[2], 1'b1);
    foreach (rows[k])
    begin
      if (rows[k].b)
        b_write(rows[k].i, rows[k].v);
      else
        cmd({23'h0, 2'h0, rows[k].i, 1'b0, rows[k].v, 2'h3});
      cmd({23'h0, 2'h0, rows[k].i, 4'h1});
      apb(1'b0, 12'h008, 32'h0);
      check(rd[7:0], rows[k].x);
      apb(1'b0, 12'h004, 32'h0);
      check(rd[1], rows[k].x == 8'h00);
    end
    apb(1'b0, 12'h00C, 32'h0);
    check({serr, rd}, 33'h1_0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0031);
    apb(1'b1, 12'h000, 32'h0000_0051);
    check(serr, 1'b1);
    // the running read of token 3 shows in the command readback
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0000_0031);
    cmd(32'h0000_0000);
    apb(1'b0, 12'h008, 32'h0);
    check(rd[7:0], 8'hFF);
    // reset in the middle of a read strobe drops every pin at once
    apb(1'b1, 12'h000, 32'h0000_0031);
    repeat (6) @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    check({pready, pins.token_select_n, pins.output_enable_n,
      pins.data_oe}, 4'h6);
    presetn <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    check(rd[3:0], 4'h0);
    cmd(32'h0000_0031);
    apb(1'b0, 12'h008, 32'h0);
    check(rd[7:0], 8'hFF);
    print_verdict();
  end
endmodule : dps_host_tb_top
`default_nettype wire

/* verification/dps_token_model.sv */
// dps_token_model.sv: behavioural two-port token device
// assumes port a is the controller's pins and port b the bench
`timescale 1ns/1ns
`default_nettype none
module dps_token_model
(
  input wire dps_pkg::dps_pins_s pins,
  input wire logic sel_b_n,
  input wire logic we_b_n,
  input wire logic [2:0] idx_b,
  input wire logic bit_b,
  output logic [7:0] data_a
);
  import dps_pkg::*;
  // eight latches; power-up leaves side b holding all of them
  logic [7:0] req_a = 8'h00;
  logic [7:0] req_b = 8'hFF;
  logic [7:0] own_a = 8'h00;
  logic [7:0] own_b = 8'hFF;
  logic [7:0] q_a = 8'h00;
  // one write; release hands over to a waiting request
  task automatic put(input logic b, input logic [2:0] i, input logic v);
    if (b)
      req_b[i] = !v;
    else
      req_a[i] = !v;
    if (!req_a[i])
      own_a[i] = 1'b0;
    if (!req_b[i])
      own_b[i] = 1'b0;
    if (req_a[i] && !own_b[i])
      own_a[i] = 1'b1;
    if (req_b[i] && !own_a[i])
      own_b[i] = 1'b1;
  endtask : put
  always @(negedge pins.write_n)
    if (!pins.token_select_n)
      put(1'b0, pins.token_index, pins.data_out[0]);
  always @(negedge we_b_n)
    if (!sel_b_n)
      put(1'b1, idx_b, bit_b);
  // latched at select and enable; a released bus shows the inverse
  // flags reach only the data pins and gate nothing else
  always @(negedge (pins.token_select_n | pins.output_enable_n))
    q_a = {8{!own_a[pins.token_index]}};
  assign data_a = (!pins.token_select_n && !pins.output_enable_n) ?
    q_a : ~q_a;
endmodule : dps_token_model
`default_nettype wire

/* verilog/dps_consts.svh */
// dps_consts.svh: offsets, fields and timing counts for the token controller
// assumes a 250 MHz pclk and a single port of the dual-port token logic
`ifndef DPS_CONSTS_SVH
`define DPS_CONSTS_SVH
`define DPS_OFS_CMD 12'h000
`define DPS_OFS_STATUS 12'h004
`define DPS_OFS_DATA 12'h008
`define DPS_CMD_START_BIT 0
`define DPS_CMD_WRITE_BIT 1
`define DPS_CMD_VALUE_BIT 2
`define DPS_CMD_INDEX_LSB 4
`define DPS_CMD_INDEX_MSB 6
`define DPS_CMD_INIT_BIT 8
`define DPS_STAT_BUSY_BIT 0
`define DPS_STAT_OWN_BIT 1
`define DPS_STAT_INIT_BIT 2
`define DPS_STAT_ERR_BIT 3
`define DPS_CMD_RESET 32'h0000_0000
`define DPS_TOKENS 4'h8
// strobe widths in ns and the derived cycle counts (rounded up)
`define DPS_T_SETUP_NS 10
`define DPS_T_PULSE_NS 30
`define DPS_T_GAP_NS 10
`define DPS_CLK_NS 4
`define DPS_SETUP_CYC \
  4'((`DPS_T_SETUP_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)
`define DPS_PULSE_CYC \
  4'((`DPS_T_PULSE_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)
`define DPS_GAP_CYC \
  4'((`DPS_T_GAP_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)
`endif

/* verilog/dps_host.sv */
// dps_host.sv: APB-controlled master for one port of the dual-port tokens
// assumes pins of the device arrive asynchronously and are resynchronised
`timescale 1ns/1ns
`default_nettype none
`include "dps_consts.svh"
module dps_host
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output var dps_pkg::dps_pins_s pins,
  input wire logic [7:0] data_in
);
  import dps_pkg::*;

  // decode shared by read and write paths
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a == o);
  endfunction : hit

  logic [7:0] sync1;
  logic [7:0] sync2;
  dps_state_e state;
  dps_state_e next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic busy;
  logic next_busy;
  logic op_write;
  logic next_op_write;
  logic op_value;
  logic next_op_value;
  logic [2:0] op_index;
  logic [2:0] next_op_index;
  logic init_run;
  logic next_init_run;
  logic init_done;
  logic next_init_done;
  logic owned;
  logic next_owned;
  logic err;
  logic next_err;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  dps_pins_s next_pins;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic access;

  // two flops on the data pins before any logic reads them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1 <= 8'h00;
      sync2 <= 8'h00;
    end
    else
    begin
      sync1 <= data_in;
      sync2 <= sync1;
    end
  end

  assign access = psel && penable && !pready;

  // command decode, pin sequencer and status in one group
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_busy = busy;
    next_op_write = op_write;
    next_op_value = op_value;
    next_op_index = op_index;
    next_init_run = init_run;
    next_init_done = init_done;
    next_owned = owned;
    next_err = err;
    next_rdata = rdata;
    next_pins = pins;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    // apb slave: one wait state, answer in the second access cycle
    if (access)
    begin
      next_pready = 1'b1;
      if (pwrite)
      begin
        if (hit(paddr, `DPS_OFS_CMD))
        begin
          if (busy)
            next_pslverr = 1'b1; // refused while a cycle runs
          else if (pwdata[`DPS_CMD_INIT_BIT])
          begin
            // both ports must free every token at start-up
            next_init_run = 1'b1;
            next_init_done = 1'b0;
            next_op_write = 1'b1;
            next_op_value = 1'b1;
            next_op_index = 3'h0;
            next_busy = 1'b1;
            next_state = DPS_SETUP;
            next_cnt = `DPS_SETUP_CYC;
          end
          else if (pwdata[`DPS_CMD_START_BIT])
          begin
            next_op_write = pwdata[`DPS_CMD_WRITE_BIT];
            next_op_value = pwdata[`DPS_CMD_VALUE_BIT];
            next_op_index =
              pwdata[`DPS_CMD_INDEX_MSB:`DPS_CMD_INDEX_LSB];
            next_busy = 1'b1;
            next_state = DPS_SETUP;
            next_cnt = `DPS_SETUP_CYC;
          end
        end
        else if (!hit(paddr, `DPS_OFS_STATUS) && !hit(paddr, `DPS_OFS_DATA))
          next_pslverr = 1'b1;
      end
      else
      begin
        if (hit(paddr, `DPS_OFS_CMD))
          next_prdata = {23'h000000, init_run, 1'b0, op_index, 1'b0,
                         op_value, op_write, busy};
        else if (hit(paddr, `DPS_OFS_STATUS))
          next_prdata = {28'h0000000, err, init_done, owned, busy};
        else if (hit(paddr, `DPS_OFS_DATA))
          next_prdata = {24'h000000, rdata};
        else
        begin
          next_prdata = 32'h0000_0000;
          next_pslverr = 1'b1;
        end
      end
    end
    // device pin sequencer
    unique case (state)
      DPS_IDLE:
      begin
        // chip enable and token select high: the port sleeps
        next_pins.token_select_n = 1'b1;
        next_pins.chip_enable_n = 1'b1;
        next_pins.write_n = 1'b1;
        next_pins.output_enable_n = 1'b1;
        next_pins.data_oe = 1'b0;
      end
      DPS_SETUP:
      begin
        // token space only; memory chip enable stays high
        next_pins.token_select_n = 1'b0;
        next_pins.chip_enable_n = 1'b1;
        next_pins.token_index = op_index;
        next_pins.data_out = {7'h00, op_value};
        next_pins.data_oe = op_write;
        if (cnt <= 4'h1)
        begin
          next_state = DPS_STROBE;
          next_cnt = `DPS_PULSE_CYC;
        end
        else
          next_cnt = cnt - 4'h1;
      end
      DPS_STROBE:
      begin
        next_pins.write_n = !op_write;
        next_pins.output_enable_n = op_write;
        if (cnt <= 4'h1)
        begin
          next_state = DPS_HOLD;
          if (!op_write)
          begin
            next_rdata = sync2;
            next_owned = (sync2 == 8'h00);
            next_err = (sync2 != 8'h00) && (sync2 != 8'hFF);
          end
        end
        else
          next_cnt = cnt - 4'h1;
      end
      DPS_HOLD:
      begin
        // drop strobes so the next read recaptures the flag
        next_pins.write_n = 1'b1;
        next_pins.output_enable_n = 1'b1;
        next_pins.token_select_n = 1'b1;
        next_state = DPS_GAP;
        next_cnt = `DPS_GAP_CYC;
      end
      DPS_GAP:
      begin
        next_pins.data_oe = 1'b0;
        if (cnt <= 4'h1)
        begin
          if (init_run && (op_index != 3'h7))
          begin
            // walk all eight latches
            next_op_index = op_index + 3'h1;
            next_state = DPS_SETUP;
            next_cnt = `DPS_SETUP_CYC;
          end
          else
          begin
            if (init_run)
            begin
              next_init_run = 1'b0;
              next_init_done = 1'b1;
              next_owned = 1'b0;
            end
            else if (op_write && op_value)
              next_owned = 1'b0;
            next_busy = 1'b0;
            next_state = DPS_IDLE;
          end
        end
        else
          next_cnt = cnt - 4'h1;
      end
    endcase
  end

  // registers only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= DPS_IDLE;
      cnt <= 4'h0;
      busy <= 1'b0;
      op_write <= 1'b0;
      op_value <= 1'b1;
      op_index <= 3'h0;
      init_run <= 1'b0;
      init_done <= 1'b0;
      owned <= 1'b0;
      err <= 1'b0;
      rdata <= 8'h00;
      pins <= '{token_select_n: 1'b1, chip_enable_n: 1'b1, write_n: 1'b1,
                output_enable_n: 1'b1, token_index: 3'h0,
                data_out: 8'h00, data_oe: 1'b0};
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      busy <= next_busy;
      op_write <= next_op_write;
      op_value <= next_op_value;
      op_index <= next_op_index;
      init_run <= next_init_run;
      init_done <= next_init_done;
      owned <= next_owned;
      err <= next_err;
      rdata <= next_rdata;
      pins <= next_pins;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end
endmodule : dps_host
`default_nettype wire

/* verilog/dps_pkg.sv */
// dps_pkg.sv: types shared by the token controller
// assumes dps_consts.svh is compiled alongside
package dps_pkg;
  typedef enum logic [2:0] {
    DPS_IDLE,
    DPS_SETUP,
    DPS_STROBE,
    DPS_HOLD,
    DPS_GAP
  } dps_state_e;
  // pins that travel to the device port together
  typedef struct packed {
    logic token_select_n;
    logic chip_enable_n;
    logic write_n;
    logic output_enable_n;
    logic [2:0] token_index;
    logic [7:0] data_out;
    logic data_oe;
  } dps_pins_s;
endpackage : dps_pkg
